// ### hw/hps_device.sv
`timescale 1ns/10ps
`include "hps_regs.svh"
module hps_device #(
	parameter int MS_CYCLES = `HPS_MS_NS / `HPS_CLK_NS
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Link to the controller
	hps_link_if.device       link,
	// Digitised analog or PWM input, full scale at 8'hff
	input  wire logic [7:0]  analog_code,
	// Drive towards the output stage
	output logic      [7:0]  drive_level,
	output logic             drive_on,
	output logic             fixed_freq_drive,
	output logic      [6:0]  fixed_drive_period
);

	// ----------------------------------------
	// Effect library
	// ----------------------------------------
	// Each effect has four segments: {ramp, signed level, duration in steps}.
	function automatic logic [16:0] rom_seg(input logic [6:0] id, input logic [1:0] seg);
		case (seg)
			2'h0:    rom_seg = {1'b0, 8'h7f, 8'(4'h2 + {1'b0, id[2:0]})};
			2'h1:    rom_seg = {id[0], 8'h30 + {4'h0, id[3:0]}, 8'(4'h4 + {1'b0, id[6:4]})};
			2'h2:    rom_seg = {1'b0, 8'he0, 8'(3'h1 + {1'b0, id[1:0]})};
			default: rom_seg = {1'b0, 8'h90, 8'(3'h2 + {1'b0, id[4:3]})};
		endcase
	endfunction

	// Class 0 overdrive, 1 positive sustain, 2 negative sustain, 3 brake.
	function automatic logic [1:0] seg_class(input logic [6:0] id, input logic [1:0] seg);
		logic signed [7:0] lv [4];
		logic [1:0]        imax;
		logic [1:0]        imin;
		logic [16:0]       ent;
		imax = 2'h0;
		imin = 2'h0;
		for (int k = 0; k < 4; k++) begin
			ent = rom_seg(id, 2'(k));
			lv[k] = $signed(ent[15:8]);
		end
		for (int k = 1; k < 4; k++) begin
			if (lv[k] > lv[imax]) imax = 2'(k);
			if (lv[k] < lv[imin]) imin = 2'(k);
		end
		if (seg == imax && lv[seg] > 8'sh00) seg_class = 2'h0;
		else if (seg == imin && lv[seg] < 8'sh00) seg_class = 2'h3;
		else if (lv[seg] >= 8'sh00) seg_class = 2'h1;
		else seg_class = 2'h2;
	endfunction

	function automatic logic [7:0] interp(input logic [7:0] a, input logic [7:0] b,
			input logic [8:0] t, input logic [8:0] len);
		logic signed [8:0]  diff;
		logic signed [18:0] prod;
		logic signed [18:0] q;
		diff = $signed({b[7], b}) - $signed({a[7], a});
		prod = diff * $signed({1'b0, t});
		q = prod / $signed({10'h000, len});
		interp = 8'(a + q[7:0]);
	endfunction

	function automatic logic [7:0] floor_lvl(input logic [1:0] sel);
		case (sel)
			2'h0:    floor_lvl = `HPS_FLOOR_0;
			2'h1:    floor_lvl = `HPS_FLOOR_1;
			2'h2:    floor_lvl = `HPS_FLOOR_2;
			default: floor_lvl = `HPS_FLOOR_3;
		endcase
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	function automatic hps_pkg::hps_dev_t rst_val();
		rst_val = '0;
		rst_val.st = hps_pkg::HPS_IDLE;
		rst_val.standby = `HPS_STBY_RST;
	endfunction

	localparam hps_pkg::hps_dev_t RST_VAL = rst_val();

	hps_pkg::hps_dev_t s;
	hps_pkg::hps_dev_t next_s;
	logic              ms_tick;
	logic              unit_tick;
	logic [7:0]        slot;
	logic [16:0]       seg;
	logic [7:0]        toff;
	logic signed [9:0] len;
	logic [7:0]        sidx;
	logic [7:0]        oidx;
	logic              seq_mode;
	logic              rise;
	logic              done;

	always_comb begin
		next_s = s;
		sidx = link.reg_addr - `HPS_REG_SLOT0;
		oidx = link.reg_addr - `HPS_REG_OFS0;
		slot = s.slots[s.slot_idx[2:0]];
		seg = rom_seg(slot[6:0], s.seg_idx);
		toff = s.ofs[seg_class(slot[6:0], s.seg_idx)];
		len = $signed({2'b00, seg[7:0]}) + $signed({{2{toff[7]}}, toff});
		seq_mode = s.mode == `HPS_MODE_REG || s.mode == `HPS_MODE_EDGE || s.mode == `HPS_MODE_LEVEL;
		rise = link.trig && !s.trig_q;
		done = 1'b0;
		next_s.trig_q = link.trig;
		next_s.rvalid = 1'b0;

		// Millisecond and step ticks.
		ms_tick = s.ms_cnt == 15'(MS_CYCLES - 1);
		next_s.ms_cnt = ms_tick ? 15'h0000 : 15'(s.ms_cnt + 15'h0001);
		unit_tick = 1'b0;
		if (ms_tick) begin
			next_s.u5_cnt = (s.u5_cnt == `HPS_U5_LAST) ? 3'h0 : 3'(s.u5_cnt + 3'h1);
			unit_tick = s.fine || s.u5_cnt == `HPS_U5_LAST;
		end

		// Sequencer.
		case (s.st)
			hps_pkg::HPS_IDLE: begin
				if (s.go) begin
					next_s.slot_idx = 4'h0;
					next_s.st = hps_pkg::HPS_LOAD;
				end
			end
			hps_pkg::HPS_LOAD: begin
				if (s.slot_idx == `HPS_SLOTS || slot == 8'h00) begin
					done = 1'b1;
					next_s.st = hps_pkg::HPS_IDLE;
				end else if (slot[`HPS_PAUSE_BIT]) begin
					next_s.pause_cnt = 11'(slot[6:0]) * 11'(`HPS_PAUSE_MS);
					next_s.ms_cnt = 15'h0000;
					next_s.st = hps_pkg::HPS_PAUSE;
				end else begin
					next_s.seg_idx = 2'h0;
					next_s.st = hps_pkg::HPS_SEGI;
				end
			end
			hps_pkg::HPS_SEGI: begin
				next_s.start_lvl = s.level;
				next_s.elapsed = 9'h000;
				next_s.seg_len = len[8:0];
				if (len > 10'sh000) begin
					next_s.st = hps_pkg::HPS_SEG;
				end else if (s.seg_idx == `HPS_SEG_LAST) begin
					// A segment shrunk to nothing is skipped.
					next_s.slot_idx = 4'(s.slot_idx + 4'h1);
					next_s.st = hps_pkg::HPS_LOAD;
				end else begin
					next_s.seg_idx = 2'(s.seg_idx + 2'h1);
				end
			end
			hps_pkg::HPS_SEG: begin
				if (unit_tick) begin
					next_s.elapsed = 9'(s.elapsed + 9'h001);
					if (9'(s.elapsed + 9'h001) == s.seg_len) begin
						if (s.seg_idx == `HPS_SEG_LAST) begin
							next_s.slot_idx = 4'(s.slot_idx + 4'h1);
							next_s.st = hps_pkg::HPS_LOAD;
						end else begin
							next_s.seg_idx = 2'(s.seg_idx + 2'h1);
							next_s.st = hps_pkg::HPS_SEGI;
						end
					end
				end
			end
			hps_pkg::HPS_PAUSE: begin
				if (s.pause_cnt == 11'h000 || (ms_tick && s.pause_cnt == 11'h001)) begin
					next_s.slot_idx = 4'(s.slot_idx + 4'h1);
					next_s.st = hps_pkg::HPS_LOAD;
				end else if (ms_tick) begin
					next_s.pause_cnt = 11'(s.pause_cnt - 11'h001);
				end
			end
			default: next_s.st = hps_pkg::HPS_IDLE;
		endcase
		if (done) next_s.go = 1'b0;

		// Go sources; a set in the cycle of completion wins.
		if (s.mode == `HPS_MODE_EDGE && rise) next_s.go = !s.go;
		if (s.mode == `HPS_MODE_LEVEL) next_s.go = link.trig;

		// Register writes.
		if (link.reg_wr) begin
			if (link.reg_addr == `HPS_REG_MODE) begin
				next_s.mode = link.reg_wdata[`HPS_MODE_MSB:0];
				next_s.standby = link.reg_wdata[`HPS_STBY_BIT];
			end
			if (link.reg_addr == `HPS_REG_RTP) next_s.rtp_amp = link.reg_wdata;
			if (link.reg_addr >= `HPS_REG_SLOT0 && link.reg_addr <= `HPS_REG_SLOT7)
				next_s.slots[sidx[2:0]] = link.reg_wdata;
			if (link.reg_addr == `HPS_REG_GO) next_s.go = link.reg_wdata[`HPS_GO_BIT];
			if (link.reg_addr >= `HPS_REG_OFS0 && link.reg_addr <= `HPS_REG_OFS3)
				next_s.ofs[oidx[1:0]] = link.reg_wdata;
			if (link.reg_addr == `HPS_REG_ACT) next_s.linear_resonant_actuator = link.reg_wdata[`HPS_LRA_BIT];
			if (link.reg_addr == `HPS_REG_CTRL) begin
				next_s.fixed = link.reg_wdata[`HPS_FIXED_BIT];
				next_s.floor_sel = link.reg_wdata[`HPS_FLOOR_MSB:`HPS_FLOOR_LSB];
			end
			if (link.reg_addr == `HPS_REG_INTV) next_s.fine = link.reg_wdata[`HPS_FINE_BIT];
			if (link.reg_addr == `HPS_REG_PERIOD) next_s.period = link.reg_wdata[6:0];
		end

		// Cancel, standby and leaving the sequencer modes stop playback at once.
		if (!next_s.go || next_s.standby || !seq_mode) begin
			next_s.st = hps_pkg::HPS_IDLE;
		end
		if (s.standby) next_s.go = 1'b0;

		// Drive output.
		next_s.drive_on = 1'b0;
		next_s.level = 8'h00;
		if (!s.standby) begin
			case (s.mode)
				`HPS_MODE_ANALOG: begin
					next_s.drive_on = 1'b1;
					next_s.level = (analog_code < floor_lvl(s.floor_sel)) ? 8'h00 : analog_code;
				end
				`HPS_MODE_RTP: begin
					next_s.drive_on = 1'b1;
					next_s.level = s.rtp_amp;
				end
				default: begin
					if (next_s.st == hps_pkg::HPS_SEG) begin
						next_s.drive_on = 1'b1;
						next_s.level = seg[16] ? interp(s.start_lvl, seg[15:8], s.elapsed, s.seg_len) : seg[15:8];
					end
				end
			endcase
		end
		next_s.fixed_out = s.linear_resonant_actuator && s.fixed && (s.mode == `HPS_MODE_ANALOG || s.mode == `HPS_MODE_RTP);
		next_s.period_out = s.period;

		// Register reads answer one cycle later.
		if (link.reg_rd) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = 8'h00;
			if (link.reg_addr == `HPS_REG_MODE) next_s.rdata = {1'b0, s.standby, 3'h0, s.mode};
			if (link.reg_addr == `HPS_REG_RTP) next_s.rdata = s.rtp_amp;
			if (link.reg_addr >= `HPS_REG_SLOT0 && link.reg_addr <= `HPS_REG_SLOT7)
				next_s.rdata = s.slots[sidx[2:0]];
			if (link.reg_addr == `HPS_REG_GO) next_s.rdata = {7'h00, s.go};
			if (link.reg_addr >= `HPS_REG_OFS0 && link.reg_addr <= `HPS_REG_OFS3)
				next_s.rdata = s.ofs[oidx[1:0]];
			if (link.reg_addr == `HPS_REG_ACT) next_s.rdata = {s.linear_resonant_actuator, 7'h00};
			if (link.reg_addr == `HPS_REG_CTRL) next_s.rdata = {2'h0, s.fixed, 3'h0, s.floor_sel};
			if (link.reg_addr == `HPS_REG_INTV) next_s.rdata = {7'h00, s.fine};
			if (link.reg_addr == `HPS_REG_PERIOD) next_s.rdata = {1'b0, s.period};
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s <= RST_VAL;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.reg_rdata = s.rdata;
	assign link.reg_rvalid = s.rvalid;
	assign drive_level = s.level;
	assign drive_on = s.drive_on;
	assign fixed_freq_drive = s.fixed_out;
	assign fixed_drive_period = s.period_out;

endmodule // hps_device

// ### common/hps_regs.svh
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH

// ----------------------------------------
// Device register offsets
// ----------------------------------------
`define HPS_REG_MODE    8'h01
`define HPS_REG_RTP     8'h02
`define HPS_REG_SLOT0   8'h04
`define HPS_REG_SLOT7   8'h0b
`define HPS_REG_GO      8'h0c
`define HPS_REG_OFS0    8'h0d
`define HPS_REG_OFS3    8'h10
`define HPS_REG_ACT     8'h1a
`define HPS_REG_CTRL    8'h1d
`define HPS_REG_INTV    8'h1f
`define HPS_REG_PERIOD  8'h20

// ----------------------------------------
// Device field positions and reset values
// ----------------------------------------
`define HPS_MODE_MSB    2
`define HPS_STBY_BIT    6
`define HPS_STBY_RST    1'b1
`define HPS_GO_BIT      0
`define HPS_LRA_BIT     7
`define HPS_FIXED_BIT   5
`define HPS_FLOOR_MSB   1
`define HPS_FLOOR_LSB   0
`define HPS_FINE_BIT    0
`define HPS_PAUSE_BIT   7

// ----------------------------------------
// Mode encodings
// ----------------------------------------
`define HPS_MODE_REG    3'h0
`define HPS_MODE_EDGE   3'h1
`define HPS_MODE_LEVEL  3'h2
`define HPS_MODE_ANALOG 3'h3
`define HPS_MODE_AUDIO  3'h4
`define HPS_MODE_RTP    3'h5

// ----------------------------------------
// Sequencer limits and input floor levels
// ----------------------------------------
`define HPS_SLOTS       4'h8
`define HPS_SEG_LAST    2'h3
`define HPS_U5_LAST     3'h4
`define HPS_FLOOR_0     8'h00
`define HPS_FLOOR_1     8'h04
`define HPS_FLOOR_2     8'h08
`define HPS_FLOOR_3     8'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define HPS_CLK_NS      50
`define HPS_MS_NS       1000000
`define HPS_COARSE_MS   5
`define HPS_PAUSE_MS    10
`define HPS_TRIG_NS     1000

// ----------------------------------------
// Controller AXI4-Lite map
// ----------------------------------------
`define HPS_AXI_CMD     6'h00
`define HPS_AXI_STATUS  6'h04
`define HPS_AXI_TRIG    6'h08
`define HPS_CMD_RD_BIT  16
`define HPS_ST_BUSY_BIT 8
`define HPS_TRIG_LVL    0
`define HPS_TRIG_PULSE  1
`define HPS_RESP_OKAY   2'b00
`define HPS_RESP_SLVERR 2'b10

`endif

// ### common/hps_pkg.sv
package hps_pkg;

	typedef enum logic [4:0] {
		HPS_IDLE  = 5'b00001,
		HPS_LOAD  = 5'b00010,
		HPS_SEGI  = 5'b00100,
		HPS_SEG   = 5'b01000,
		HPS_PAUSE = 5'b10000
	} hps_seq_t;

	typedef struct packed {
		hps_seq_t        st;
		logic [2:0]      mode;
		logic            standby;
		logic [7:0]      rtp_amp;
		logic [7:0][7:0] slots;
		logic            go;
		logic [3:0][7:0] ofs;
		logic            linear_resonant_actuator;
		logic            fixed;
		logic [1:0]      floor_sel;
		logic            fine;
		logic [6:0]      period;
		logic [3:0]      slot_idx;
		logic [1:0]      seg_idx;
		logic [14:0]     ms_cnt;
		logic [2:0]      u5_cnt;
		logic [10:0]     pause_cnt;
		logic [8:0]      elapsed;
		logic [8:0]      seg_len;
		logic [7:0]      start_lvl;
		logic            trig_q;
		logic [7:0]      rdata;
		logic            rvalid;
		logic [7:0]      level;
		logic            drive_on;
		logic            fixed_out;
		logic [6:0]      period_out;
	} hps_dev_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [5:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [16:0] cmd;
		logic        busy;
		logic [7:0]  rd_data;
		logic        reg_wr;
		logic        reg_rd;
		logic [7:0]  reg_addr;
		logic [7:0]  reg_wdata;
		logic        trig;
		logic [7:0]  pulse_cnt;
	} hps_host_t;

endpackage

// ### common/hps_link_if.sv
`timescale 1ns/10ps
interface hps_link_if;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic       trig;

	modport device (
		input  reg_wr,
		input  reg_rd,
		input  reg_addr,
		input  reg_wdata,
		input  trig,
		output reg_rdata,
		output reg_rvalid
	);

	modport host (
		output reg_wr,
		output reg_rd,
		output reg_addr,
		output reg_wdata,
		output trig,
		input  reg_rdata,
		input  reg_rvalid
	);
endinterface // hps_link_if

// ### hw/hps_host.sv
`timescale 1ns/10ps
`include "hps_regs.svh"
module hps_host #(
	parameter int TRIG_CYCLES = (`HPS_TRIG_NS + `HPS_CLK_NS - 1) / `HPS_CLK_NS
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// AXI4-Lite slave
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Link to the device
	hps_link_if.host         link
);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		for (int k = 0; k < 4; k++) begin
			merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
		end
	endfunction

	hps_pkg::hps_host_t s;
	hps_pkg::hps_host_t next_s;
	logic [31:0]        wd;

	always_comb begin
		next_s = s;
		next_s.reg_wr = 1'b0;
		next_s.reg_rd = 1'b0;
		wd = 32'h0000_0000;
		if (link.reg_rvalid) begin
			next_s.rd_data = link.reg_rdata;
			next_s.busy = 1'b0;
		end
		if (s.pulse_cnt != 8'h00) begin
			// The pulse is stretched so the device side sees each edge.
			next_s.pulse_cnt = 8'(s.pulse_cnt - 8'h01);
			if (s.pulse_cnt == 8'h01) next_s.trig = 1'b0;
		end

		// ----------------------------------------
		// Write channel
		// ----------------------------------------
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `HPS_RESP_OKAY;
			case (s.aw_addr)
				`HPS_AXI_CMD: begin
					if (s.busy) begin
						next_s.bresp = `HPS_RESP_SLVERR;
					end else begin
						wd = merge({15'h0000, s.cmd}, s.w_data, s.w_strb);
						next_s.cmd = wd[16:0];
						next_s.reg_addr = wd[15:8];
						next_s.reg_wdata = wd[7:0];
						next_s.reg_rd = wd[`HPS_CMD_RD_BIT];
						next_s.reg_wr = !wd[`HPS_CMD_RD_BIT];
						next_s.busy = wd[`HPS_CMD_RD_BIT];
					end
				end
				`HPS_AXI_TRIG: begin
					if (s.w_strb[0]) begin
						next_s.trig = s.w_data[`HPS_TRIG_LVL];
						next_s.pulse_cnt = 8'h00;
						if (s.w_data[`HPS_TRIG_PULSE]) begin
							next_s.trig = 1'b1;
							next_s.pulse_cnt = 8'(TRIG_CYCLES);
						end
					end
				end
				default: next_s.bresp = `HPS_RESP_SLVERR;
			endcase
		end

		// ----------------------------------------
		// Read channel
		// ----------------------------------------
		if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
		if (s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = `HPS_RESP_OKAY;
			case (s_axi_araddr)
				`HPS_AXI_CMD:    next_s.rdata = {15'h0000, s.cmd};
				`HPS_AXI_STATUS: next_s.rdata = {23'h000000, s.busy, s.rd_data};
				`HPS_AXI_TRIG:   next_s.rdata = {30'h00000000, s.pulse_cnt != 8'h00, s.trig};
				default: begin
					next_s.rdata = 32'h0000_0000;
					next_s.rresp = `HPS_RESP_SLVERR;
				end
			endcase
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
	assign link.reg_wr = s.reg_wr;
	assign link.reg_rd = s.reg_rd;
	assign link.reg_addr = s.reg_addr;
	assign link.reg_wdata = s.reg_wdata;
	assign link.trig = s.trig;

endmodule // hps_host

// ### verif/hps_link_monitor.sv
`timescale 1ns/10ps
module hps_link_monitor (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       nrst,
	// Link from the controller
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       trig,
	// Link from the device
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// ----------------------------------------
	// Shadow of the device registers
	// ----------------------------------------
	logic [7:0] shadow [256];
	logic [7:0] sh_now;
	logic       stby;
	logic       kept;
	assign sh_now = shadow[reg_addr];
	assign stby = shadow[1][6];
	assign kept = reg_addr inside {[8'h04:8'h0b], [8'h0d:8'h10]};
	// Standby is on out of reset, so the shadow starts with that bit set.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 256; i++)
				shadow[i] <= (i == 1) ? 8'h40 : 8'h00;
		end else if (reg_wr) begin
			shadow[reg_addr] <= reg_wdata;
		end
	end
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("link read not answered in the next cycle");
	rd_only_a: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("link read data without a read");
	strobe_excl_a: assert property (!(reg_wr && reg_rd))
		else $error("link read and write in one cycle");
	addr_hold_a: assert property (reg_rd |=> $stable(reg_addr))
		else $error("link address moved after a read");
	trig_width_a: assert property ($rose(trig) |-> trig[*8] ##1 trig[*8] ##1 trig[*4])
		else $error("trigger pulse shorter than one microsecond");
	slot_keep_a: assert property (reg_rd && kept |=> reg_rdata == $past(sh_now))
		else $error("slot or offset read back wrong");
	period_keep_a: assert property (reg_rd && reg_addr == 8'h20 |=> ((reg_rdata ^ $past(sh_now)) & 8'h7f) == 8'h00)
		else $error("drive period read back wrong");
	standby_go_a: assert property (reg_rd && reg_addr == 8'h0c && stby && $past(stby) |=> !reg_rdata[0])
		else $error("go read high in standby");
	cover property (reg_rd && reg_addr == 8'h0c ##1 reg_rdata[0]);
	cover property ($rose(trig));
	cover property (reg_wr && reg_addr == 8'h0c && reg_wdata[0]);
endmodule // hps_link_monitor

// ### verif/haptic_playback_sequencer_tb_top.sv
`timescale 1ns/10ps
module haptic_playback_sequencer_tb_top;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [5:0]  awaddr = 6'h00;
	logic [5:0]  araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [7:0]  analog_code = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid, drive_on, fixed_freq_drive;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [7:0]  drive_level, v, p, amp;
	logic [6:0]  fixed_drive_period;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          mdl [256];

	always #25 ref_clk = ~ref_clk;

	hps_link_if hps_link_if_inst ();
	hps_device #(.MS_CYCLES(20)) hps_device_inst (
		.ref_clk(ref_clk), .nrst(nrst), .link(hps_link_if_inst), .analog_code(analog_code),
		.drive_level(drive_level), .drive_on(drive_on), .fixed_freq_drive(fixed_freq_drive),
		.fixed_drive_period(fixed_drive_period));
	hps_host hps_host_inst (
		.ref_clk(ref_clk), .nrst(nrst), .link(hps_link_if_inst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	hps_link_monitor hps_link_monitor_inst (
		.ref_clk(ref_clk), .nrst(nrst), .reg_wr(hps_link_if_inst.reg_wr),
		.reg_rd(hps_link_if_inst.reg_rd), .reg_addr(hps_link_if_inst.reg_addr),
		.reg_wdata(hps_link_if_inst.reg_wdata), .trig(hps_link_if_inst.trig),
		.reg_rdata(hps_link_if_inst.reg_rdata), .reg_rvalid(hps_link_if_inst.reg_rvalid));

	// ----------------------------------------
	// Bus and device access tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic tmo();
		error_cnt++;
		stop_test();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, s);
			error_cnt++;
		end
	endtask
	task automatic axw(input logic [5:0] a, input logic [31:0] x);
		int n;
		n = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		if (bvalid !== 1'b1)
			tmo();
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [5:0] a);
		int n;
		n = 0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		if (rvalid !== 1'b1)
			tmo();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic dw(input logic [7:0] a, input logic [7:0] x);
		mdl[a] = x;
		axw(6'h00, {16'h0000, a, x});
	endtask
	// A device read is only seen through the status word, so busy is polled.
	task automatic dr(input logic [7:0] a);
		int n;
		n = 0;
		axw(6'h00, {15'h0000, 1'b1, a, 8'h00});
		do begin
			axr(6'h04);
			n++;
		end while (d[8] !== 1'b0 && n < 50);
		if (d[8] !== 1'b0)
			tmo();
		v = d[7:0];
	endtask
	task automatic sweep(input int lo, input int hi);
		for (int a = lo; a <= hi; a++) begin
			dr(a[7:0]);
			chk("device register", mdl[a], {24'h0, v});
		end
	endtask
	task automatic wait_on(input logic want);
		int n;
		n = 0;
		while (drive_on !== want && n < 5000) begin
			@(posedge ref_clk);
			n++;
		end
		chk("drive_on", want, drive_on);
	endtask

	initial begin
		void'($urandom(32'hd2677e07));
		for (int i = 0; i < 256; i++)
			mdl[i] = 0;
		mdl[1] = 8'h40;
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		sweep(1, 16);
		for (int a = 4; a < 17; a++)
			if (a != 12)
				dw(a[7:0], 8'($urandom));
		sweep(4, 11);
		sweep(13, 16);
		axr(6'h3c);
		chk("unmapped response", 2'b10, r);
		for (int a = 13; a < 17; a++)
			dw(a[7:0], 8'h00);
		dw(8'h04, 8'h01);
		dw(8'h05, 8'h82);
		dw(8'h06, 8'h02);
		dw(8'h07, 8'h00);
		dw(8'h1f, 8'h01);
		dw(8'h01, 8'h00);
		dw(8'h0c, 8'h01);
		wait_on(1'b1);
		v = 8'h01;
		for (int i = 0; i < 4000 && v[0] === 1'b1; i++)
			dr(8'h0c);
		chk("go after sequence", 0, v);
		dw(8'h0c, 8'h01);
		wait_on(1'b1);
		dw(8'h0c, 8'h00);
		repeat (4) @(posedge ref_clk);
		chk("drive_on", 0, drive_on);
		dw(8'h1f, 8'h00);
		dw(8'h0c, 8'h01);
		wait_on(1'b1);
		// With 5 ms steps the first effect is still in its overdrive segment here; 1 ms steps would have left it.
		repeat (150) @(posedge ref_clk);
		chk("overdrive level at coarse step", 8'h7f, drive_level);
		dw(8'h01, 8'h40);
		repeat (4) @(posedge ref_clk);
		chk("drive_on", 0, drive_on);
		mdl[12] = 0;
		sweep(1, 16);
		dw(8'h1f, 8'h00);
		dw(8'h01, 8'h01);
		axw(6'h08, 32'h2);
		repeat (30) @(posedge ref_clk);
		dr(8'h0c);
		chk("go by edge", 1, v);
		axw(6'h08, 32'h2);
		repeat (30) @(posedge ref_clk);
		dr(8'h0c);
		chk("go by edge", 0, v);
		dw(8'h01, 8'h02);
		axw(6'h08, 32'h1);
		repeat (30) @(posedge ref_clk);
		dr(8'h0c);
		chk("go by level", 1, v);
		axw(6'h08, 32'h0);
		dr(8'h0c);
		chk("go by level", 0, v);
		for (int a = 13; a < 17; a++)
			dw(a[7:0], 8'($urandom));
		p = 8'($urandom);
		amp = 8'($urandom) | 8'h01;
		dw(8'h1a, 8'h80);
		dw(8'h1d, 8'h20);
		dw(8'h20, p);
		dw(8'h02, amp);
		dw(8'h01, 8'h05);
		repeat (4) @(posedge ref_clk);
		chk("amplitude", amp, drive_level);
		chk("drive_on", 1, drive_on);
		chk("fixed frequency", 1, fixed_freq_drive);
		chk("drive period", p[6:0], fixed_drive_period);
		dr(8'h20);
		chk("period read", p[6:0], v[6:0]);
		dw(8'h01, 8'h00);
		repeat (4) @(posedge ref_clk);
		chk("drive_on", 0, drive_on);
		dw(8'h01, 8'h03);
		for (int s = 1; s < 4; s++) begin
			dw(8'h1d, 8'h20 | 8'(s));
			analog_code <= 8'(4 << (s - 1)) - 8'h01;
			repeat (4) @(posedge ref_clk);
			chk("floor level", 0, drive_level);
			analog_code <= 8'(4 << (s - 1));
			repeat (4) @(posedge ref_clk);
			chk("floor level", 4 << (s - 1), drive_level);
		end
		analog_code <= 8'hff;
		repeat (4) @(posedge ref_clk);
		chk("full scale", 8'hff, drive_level);
		stop_test();
	end
endmodule // haptic_playback_sequencer_tb_top
